/* iovf_fault_response.sv */
// module: input overvoltage fault detection, response sequencing and its two command registers
`timescale 1ns/1ps
`default_nettype none
module iovf_fault_response #(
  parameter int UNIT_W = 24
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire iovf_pkg::iovf_cmd_t cmd,
  input  wire logic [15:0]        vin_meas,
  input  wire logic [UNIT_W-1:0]  unit_cycles,
  input  wire logic               ctrl_pin,
  input  wire logic               operation_on,
  input  wire logic               status_clear,
  input  wire logic               clear_faults,
  input  wire logic               other_fault,
  output logic                    out_enable,
  output logic                    fault_status,
  output logic                    latched_off,
  output logic [15:0]             rd_data,
  output logic                    rd_valid,
  output logic                    cmd_nack
);
  import iovf_pkg::*;

  logic [15:0]       limit_reg;
  logic [7:0]        response_reg;
  iovf_state_t       state_reg, state_next;
  logic [2:0]        ctrl_sync_reg;
  logic              ctrl_reg;
  logic [2:0]        tries_reg, tries_next;
  logic [UNIT_W-1:0] cyc_reg;
  logic [7:0]        units_reg;
  logic              fault_status_reg;

  // pin goes through three flops; a change counts once the last two agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_sync_reg <= 3'h0;
      ctrl_reg      <= 1'b0;
    end else if (ce) begin
      ctrl_sync_reg <= {ctrl_sync_reg[1:0], ctrl_pin};
      if (ctrl_sync_reg[1] == ctrl_sync_reg[2]) begin
        ctrl_reg <= ctrl_sync_reg[2];
      end
    end
  end

  wire       run_cmd    = ctrl_reg & operation_on;
  wire       fault      = vin_meas > limit_reg;
  wire [1:0] resp       = response_reg[RESP_HI:RESP_LO];
  wire [2:0] retry      = response_reg[RETRY_HI:RETRY_LO];
  wire [2:0] dly        = response_reg[DELAY_HI:DELAY_LO];
  wire [7:0] units_goal = 8'h01 << dly;
  wire       unit_end   = (cyc_reg + 1'b1 >= unit_cycles);
  wire       delay_done = unit_end && (units_reg + 8'h01 >= units_goal);
  wire       timing     = (state_reg == ST_OPERATE_DELAY) || (state_reg == ST_SPACING);
  wire       clear_req  = status_clear | clear_faults;
  wire       may_retry  = (retry == RETRY_FOREVER) || (tries_reg < retry);

  // write decode: limit takes a word, response takes the low byte
  wire wr_limit = cmd.valid && cmd.write && (cmd.code == CMD_LIMIT);
  wire wr_resp  = cmd.valid && cmd.write && (cmd.code == CMD_RESPONSE);
  wire rd_limit = cmd.valid && !cmd.write && (cmd.code == CMD_LIMIT);
  wire rd_resp  = cmd.valid && !cmd.write && (cmd.code == CMD_RESPONSE);
  wire bad_code = cmd.valid && (cmd.code != CMD_LIMIT) && (cmd.code != CMD_RESPONSE);
  wire [15:0] rd_mux = rd_limit ? limit_reg : {8'h00, response_reg};

  // choose where a fault with retries leads: spacing before a restart, or latch
  iovf_state_t retry_target;
  assign retry_target = may_retry ? ST_SPACING : ST_LATCHED;

  always_comb begin
    state_next = state_reg;
    tries_next = tries_reg;
    unique case (state_reg)
      ST_OFF: begin
        tries_next = 3'h0;
        if (run_cmd) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault) begin
          unique case (resp)
            RESP_IGNORE:  state_next = ST_RUN;
            RESP_OPERATE: state_next = ST_OPERATE_DELAY;
            RESP_DISABLE: state_next = retry_target;
            RESP_LATCH:   state_next = ST_LATCHED;
          endcase
        end
      end
      ST_OPERATE_DELAY: begin
        // output stays on while the delay runs
        if (delay_done) begin
          state_next = fault ? retry_target : ST_RUN;
        end
      end
      ST_SPACING: begin
        if (delay_done) begin
          state_next = ST_RUN;
          if (retry != RETRY_FOREVER) begin
            tries_next = tries_reg + 3'h1;
          end
        end
      end
      ST_LATCHED: begin
        if (clear_req) begin
          state_next = ST_RUN;
          tries_next = 3'h0;
        end
      end
      default: state_next = ST_OFF;
    endcase
    // an off command ends every sequence; the later on is the off-then-on clear
    if (!run_cmd) begin
      state_next = ST_OFF;
    end else if (other_fault && state_reg != ST_OFF) begin
      state_next = ST_LATCHED;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
      tries_reg <= 3'h0;
      cyc_reg   <= '0;
      units_reg <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      tries_reg <= tries_next;
      // counters restart on every state change so each delay is whole
      if (!timing || state_next != state_reg) begin
        cyc_reg   <= '0;
        units_reg <= 8'h00;
      end else if (unit_end) begin
        cyc_reg   <= '0;
        units_reg <= units_reg + 8'h01;
      end else begin
        cyc_reg   <= cyc_reg + 1'b1;
      end
    end
  end

  // sticky status: a new fault in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_status_reg <= 1'b0;
    end else if (ce) begin
      if (fault && resp != RESP_IGNORE) begin
        fault_status_reg <= 1'b1;
      end else if (clear_req) begin
        fault_status_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      limit_reg    <= LIMIT_RESET;
      response_reg <= RESPONSE_RESET;
      rd_data      <= 16'h0000;
      rd_valid     <= 1'b0;
      cmd_nack     <= 1'b0;
    end else if (ce) begin
      if (wr_limit) begin
        limit_reg <= cmd.wdata;
      end
      if (wr_resp) begin
        response_reg <= cmd.wdata[7:0];
      end
      rd_valid <= rd_limit | rd_resp;
      if (rd_limit | rd_resp) begin
        rd_data <= rd_mux;
      end
      cmd_nack <= bad_code;
    end
  end

  // out_enable and latched_off follow the next state so they line up with it; fault_status repeats fault_status_reg one cycle later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_enable   <= 1'b0;
      latched_off  <= 1'b0;
      fault_status <= 1'b0;
    end else if (ce) begin
      out_enable   <= (state_next == ST_RUN) || (state_next == ST_OPERATE_DELAY);
      latched_off  <= state_next == ST_LATCHED;
      fault_status <= fault_status_reg;
    end
  end
endmodule : iovf_fault_response
`default_nettype wire

/* iovf_fault_response_properties.sv */
// checker: port properties of the input overvoltage fault block
`timescale 1ns/1ps
`default_nettype none
module iovf_fault_response_properties (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic                ce,
  input wire iovf_pkg::iovf_cmd_t cmd,
  input wire logic [15:0]         vin_meas,
  input wire logic                operation_on,
  input wire logic                status_clear,
  input wire logic                clear_faults,
  input wire logic                other_fault,
  input wire logic                out_enable,
  input wire logic                fault_status,
  input wire logic                latched_off,
  input wire logic                rd_valid,
  input wire logic                cmd_nack
);
  import iovf_pkg::*;
  logic [7:0]  resp;
  logic [15:0] lim;
  wire         known = cmd.code == CMD_LIMIT || cmd.code == CMD_RESPONSE;
  wire         hit   = ce && cmd.valid && cmd.write;
  wire         flt   = vin_meas > lim;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // shadow copies, so the properties know the programmed mode and limit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resp <= RESPONSE_RESET;
      lim  <= LIMIT_RESET;
    end else begin
      if (hit && cmd.code == CMD_RESPONSE) resp <= cmd.wdata[7:0];
      if (hit && cmd.code == CMD_LIMIT) lim <= cmd.wdata;
    end
  end
  a_read_answer: assert property (
    ce && cmd.valid && !cmd.write && known |=> rd_valid) else $error("read not answered");
  a_bad_code: assert property (
    ce && cmd.valid && !known |=> cmd_nack && !rd_valid) else $error("bad code accepted");
  a_ignore_mode: assert property (
    ce && resp[7:6] == RESP_IGNORE && $stable(resp) && !fault_status |=> !fault_status)
    else $error("ignored fault set status");
  a_disable_fast: assert property (
    ce && resp[7] && out_enable && flt |=> !out_enable) else $error("output not cut");
  a_latch_off: assert property (
    latched_off |-> !out_enable) else $error("latched but on");
  a_latch_clear: assert property (
    ce && latched_off && (status_clear || clear_faults) && operation_on && !other_fault && !flt
    |=> out_enable && !latched_off) else $error("clear did not restart");
  a_retry_forever: assert property (
    ce && resp[7:6] == RESP_DISABLE && resp[5:3] == RETRY_FOREVER && !other_fault
    && !latched_off |=> !latched_off) else $error("endless retry latched");
  a_no_retry: assert property (
    ce && resp[7:6] == RESP_DISABLE && resp[5:3] == RETRY_NONE && out_enable && flt
    |-> ##[1:2] latched_off) else $error("no retry did not latch");
endmodule : iovf_fault_response_properties
bind iovf_fault_response iovf_fault_response_properties u_props (.clk_sys, .rst_n, .ce,
  .cmd, .vin_meas, .operation_on, .status_clear, .clear_faults, .other_fault,
  .out_enable, .fault_status, .latched_off, .rd_valid, .cmd_nack);
`default_nettype wire

/* iovf_fault_response_tb.sv */
// testbench: command access, fault responses and clearing of the fault block
`timescale 1ns/1ps
`default_nettype none
module iovf_fault_response_tb;
  import iovf_pkg::*;
  typedef struct packed {logic [7:0] resp; logic [7:0] n; logic on; logic lat;} iovf_row_t;
  // unit_cycles is 2, so delay field 1 gives 4 cycles and field 7 gives 256
  localparam iovf_row_t ROWS [6] = '{'{8'h00, 8'h04, 1'h1, 1'h0}, '{8'h41, 8'h02, 1'h1, 1'h0},
    '{8'h41, 8'h0C, 1'h0, 1'h1}, '{8'h80, 8'h02, 1'h0, 1'h1}, '{8'hC0, 8'h02, 1'h0, 1'h1},
    '{8'hBF, 8'h14, 1'h0, 1'h0}};
  logic        clk_sys, rst_n, ce, ctrl_pin, operation_on, status_clear, clear_faults;
  logic        other_fault, out_enable, fault_status, latched_off, rd_valid, cmd_nack;
  logic [15:0] vin_meas, rd_data;
  logic [23:0] unit_cycles;
  wire iovf_cmd_t cmd;
  int          fails, total_checks;
  iovf_fault_response #(.UNIT_W(24)) u_iovf_fault_response (.clk_sys, .rst_n, .ce, .cmd,
    .vin_meas, .unit_cycles, .ctrl_pin, .operation_on, .status_clear, .clear_faults,
    .other_fault, .out_enable, .fault_status, .latched_off, .rd_data, .rd_valid, .cmd_nack);
  iovf_host u_iovf_host (.clk_sys, .cmd);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic rd(input logic [7:0] code, input logic [15:0] e);
    u_iovf_host.xfer(1'b0, code, 16'h0000);
    tick(0);
    chk("read", e, rd_data);
    chk("rd_valid", 16'h0001, rd_valid);
  endtask : rd
  task automatic conclude();
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end
  initial begin
    {rst_n, status_clear, clear_faults, other_fault} = 4'h0;
    {ce, ctrl_pin, operation_on} = 3'h7;
    vin_meas = 16'h0000;
    unit_cycles = 24'h000002;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(CMD_LIMIT, LIMIT_RESET);
    rd(CMD_RESPONSE, {8'h00, RESPONSE_RESET});
    u_iovf_host.xfer(1'b1, CMD_LIMIT, 16'h1234);
    u_iovf_host.xfer(1'b1, CMD_RESPONSE, 16'h005A);
    rd(CMD_LIMIT, 16'h1234);
    rd(CMD_RESPONSE, 16'h005A);
    u_iovf_host.xfer(1'b0, 8'h57, 16'h0000);
    tick(0);
    chk("nack", 16'h0001, cmd_nack);
    foreach (ROWS[i]) begin
      u_iovf_host.xfer(1'b1, CMD_RESPONSE, {8'h00, ROWS[i].resp});
      vin_meas <= 16'h1235;
      tick(ROWS[i].n);
      chk("out", 16'(ROWS[i].on), out_enable);
      chk("latch", 16'(ROWS[i].lat), latched_off);
      chk("status", 16'(ROWS[i].resp[7:6] != RESP_IGNORE), fault_status);
      @(posedge clk_sys);
      vin_meas <= 16'h1234;
      {operation_on, status_clear} <= 2'h1;
      tick(2);
      @(posedge clk_sys);
      {operation_on, status_clear} <= 2'h2;
      tick(3);
      chk("restart", 16'h0001, out_enable);
    end
    // one restart attempt, then latched; vin equal to the limit is not a fault
    u_iovf_host.xfer(1'b1, CMD_RESPONSE, 16'h0089);
    vin_meas <= 16'h1235;
    tick(20);
    chk("retry once", 16'h0001, latched_off);
    chk("status set", 16'h0001, fault_status);
    @(posedge clk_sys);
    vin_meas <= 16'h1234;
    clear_faults <= 1'b1;
    @(posedge clk_sys);
    clear_faults <= 1'b0;
    tick(2);
    chk("cleared", 16'h0001, out_enable);
    chk("status cleared", 16'h0000, fault_status);
    conclude();
  end
endmodule : iovf_fault_response_tb
`default_nettype wire

/* iovf_host.sv */
// host model: issues register commands to the fault block
`timescale 1ns/1ps
`default_nettype none
module iovf_host (
  input  wire logic                clk_sys,
  output var  iovf_pkg::iovf_cmd_t cmd
);
  import iovf_pkg::*;
  initial cmd = '0;
  // idle fields carry inverted junk so stale data never passes for a command
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    cmd <= '{1'b1, w, c, d};
    @(posedge clk_sys);
    cmd <= '{1'b0, ~w, ~c, ~d};
  endtask : xfer
endmodule : iovf_host
`default_nettype wire

/* iovf_pkg.sv */
// package: constants, types and behaviour list for the input overvoltage fault response
// Behaviour
// - response 00 ignores the fault and keeps regulating.
// - response 01 keeps running for the delay, then follows the retry field if fault persists.
// - response 10 disables output at once, then follows the retry field.
// - response 11 latches off until status clear, clear-all, off-on, or reset.
// - retry field 111 retries forever until off command, reset, or other fault.
// - delay field n gives two to the n delay units, 1 up to 128.
// - the delay sets operate time under 01 and restart spacing under retries.
// - the length of one delay unit comes from the separate unit register.
// - limit word at command 0x55, 16-bit, read and write with word transfers.
// - response byte at command 0x56, read and write with byte transfers.
// - retry 000 means no restart; 001 to 110 allow that many restarts.
package iovf_pkg;
  localparam logic [7:0]  CMD_LIMIT       = 8'h55;
  localparam logic [7:0]  CMD_RESPONSE    = 8'h56;
  localparam logic [15:0] LIMIT_RESET     = 16'hFFFF;
  localparam logic [7:0]  RESPONSE_RESET  = 8'hC0;
  localparam int          RESP_HI         = 7;
  localparam int          RESP_LO         = 6;
  localparam int          RETRY_HI        = 5;
  localparam int          RETRY_LO        = 3;
  localparam int          DELAY_HI        = 2;
  localparam int          DELAY_LO        = 0;
  localparam logic [1:0]  RESP_IGNORE     = 2'h0;
  localparam logic [1:0]  RESP_OPERATE    = 2'h1;
  localparam logic [1:0]  RESP_DISABLE    = 2'h2;
  localparam logic [1:0]  RESP_LATCH      = 2'h3;
  localparam logic [2:0]  RETRY_NONE      = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER   = 3'h7;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } iovf_cmd_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_RUN, ST_OPERATE_DELAY, ST_SPACING, ST_LATCHED
  } iovf_state_t;
endpackage : iovf_pkg
